// *** logic/tdct_top.sv ***
// three 16-bit down counters with reload, plain register port and one interrupt
// assumes a same-clock register master; reads answer one cycle after the strobe
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`default_nettype none
module tdct_top (
	input wire logic clk, // 10 MHz system clock
	input wire logic rst_b, // async reset, active low
	input wire tdct_pkg::tdct_bus_type bus, // address, data and strobes
	output logic [31:0] rdata, // read data, cycle after read strobe
	output logic [2:0] tmr_irq, // per timer underflow flags
	output logic irq // unmasked status pending
);
	logic tick_a, tick_b, tick_f;
	logic [tdct_pkg::NTMR-1:0] tick;
	logic [tdct_pkg::CNT_W-1:0] load_q [tdct_pkg::NTMR];
	logic [tdct_pkg::CNT_W-1:0] cnt_q [tdct_pkg::NTMR];
	logic [1:0] ctrl_q [tdct_pkg::NTMR];
	logic [3:0] sys_q;
	logic [2:0] stat_q, mask_q, uf, clr_w, en, reload;
	logic [1:0] idx;
	logic [3:0] reg_ofs;

	assign idx = bus.addr[5:4];
	assign reg_ofs = bus.addr[3:0];

	// rate generators; the two slow ones are shared by the first two timers, the fast one feeds the third only
	tdct_tick #(.STEP(tdct_pkg::STEP_A)) u_tick_a (.clk(clk), .rst_b(rst_b), .tick(tick_a));
	tdct_tick #(.STEP(tdct_pkg::STEP_B)) u_tick_b (.clk(clk), .rst_b(rst_b), .tick(tick_b));
	tdct_tick #(.STEP(tdct_pkg::STEP_F)) u_tick_f (.clk(clk), .rst_b(rst_b), .tick(tick_f));

	// source and mode picks; the third timer takes its mode from its own control
	assign tick[0] = sys_q[tdct_pkg::SYS_SEL1_BIT] ? tick_b : tick_a;
	assign tick[1] = sys_q[tdct_pkg::SYS_SEL2_BIT] ? tick_b : tick_a;
	assign tick[2] = tick_f;
	assign reload[0] = sys_q[tdct_pkg::SYS_MODE1_BIT] | ctrl_q[0][tdct_pkg::CTRL_MODE_BIT];
	assign reload[1] = sys_q[tdct_pkg::SYS_MODE2_BIT] | ctrl_q[1][tdct_pkg::CTRL_MODE_BIT];
	assign reload[2] = ctrl_q[2][tdct_pkg::CTRL_MODE_BIT];

	// per timer counter, load, control and clear
	for (genvar i = 0; i < tdct_pkg::NTMR; i++) begin : g_tmr
		logic hit_blk;
		logic wr_load;
		logic wr_ctrl;
		assign hit_blk = (bus.addr[7:6] == 2'h0) && (idx == 2'(i));
		assign wr_load = bus.wr && hit_blk && (reg_ofs == tdct_pkg::OFS_LOAD0[3:0]);
		assign wr_ctrl = bus.wr && hit_blk && (reg_ofs == tdct_pkg::OFS_CTRL[3:0]);
		assign clr_w[i] = bus.wr && hit_blk && (reg_ofs == tdct_pkg::OFS_CLEAR[3:0]);
		assign en[i] = ctrl_q[i][tdct_pkg::CTRL_EN_BIT];
		// underflow when counting from zero on a tick while enabled
		assign uf[i] = en[i] && tick[i] && !wr_load && (cnt_q[i] == '0);

		// load register keeps the last written value for reloads
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				load_q[i] <= '0;
			end else if (wr_load) begin
				load_q[i] <= bus.wdata[tdct_pkg::CNT_W-1:0];
			end
		end

		// control register: enable and mode
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				ctrl_q[i] <= '0;
			end else if (wr_ctrl) begin
				ctrl_q[i] <= bus.wdata[1:0];
			end
		end

		// counter: write loads at once, ticks in the same cycle are ignored
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				cnt_q[i] <= '0;
			end else if (wr_load) begin
				cnt_q[i] <= bus.wdata[tdct_pkg::CNT_W-1:0];
			end else if (uf[i]) begin
				cnt_q[i] <= reload[i] ? load_q[i] : tdct_pkg::WRAP_VAL;
			end else if (en[i] && tick[i]) begin
				cnt_q[i] <= cnt_q[i] - 16'h0001;
			end
		end
	end

	// system control register for the two slow timers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sys_q <= '0;
		end else if (bus.wr && bus.addr == tdct_pkg::OFS_SYSCTL) begin
			sys_q <= bus.wdata[3:0];
		end
	end

	// sticky status: set wins over clear by write-one or by the clear register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_q <= '0;
		end else begin
			for (int k = 0; k < tdct_pkg::NTMR; k++) begin
				if (uf[k]) begin
					stat_q[k] <= 1'b1;
				end else if (clr_w[k] ||
					(bus.wr && bus.addr == tdct_pkg::OFS_STATUS && bus.wdata[k])) begin
					stat_q[k] <= 1'b0;
				end
			end
		end
	end

	// interrupt mask
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_q <= '0;
		end else if (bus.wr && bus.addr == tdct_pkg::OFS_MASK) begin
			mask_q <= bus.wdata[2:0];
		end
	end

	assign tmr_irq = stat_q;
	assign irq = |(stat_q & mask_q);

	// read decode; reads have no side effects, unmapped reads give zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= '0;
		end else if (bus.rd) begin
			if (bus.addr[7:6] == 2'h0 && idx != 2'h3 && reg_ofs == tdct_pkg::OFS_LOAD0[3:0]) begin
				rdata <= {16'h0000, load_q[idx]};
			end else if (bus.addr[7:6] == 2'h0 && idx != 2'h3 &&
				reg_ofs == tdct_pkg::OFS_VALUE[3:0]) begin
				rdata <= {16'h0000, cnt_q[idx]};
			end else if (bus.addr[7:6] == 2'h0 && idx != 2'h3 &&
				reg_ofs == tdct_pkg::OFS_CTRL[3:0]) begin
				rdata <= {30'h0, ctrl_q[idx]};
			end else if (bus.addr == tdct_pkg::OFS_SYSCTL) begin
				rdata <= {28'h0, sys_q};
			end else if (bus.addr == tdct_pkg::OFS_STATUS) begin
				rdata <= {29'h0, stat_q};
			end else if (bus.addr == tdct_pkg::OFS_MASK) begin
				rdata <= {29'h0, mask_q};
			end else begin
				rdata <= '0;
			end
		end else begin
			rdata <= '0;
		end
	end
endmodule
`default_nettype wire

// *** shared/tdct_pkg.sv ***
// constants and types shared by the triple down counter timer block
// assumes a single 10 MHz system clock; timer rates come from enable pulses
`default_nettype none
package tdct_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int SLOW_A_HZ = 508_000;
	localparam int SLOW_B_HZ = 2_000;
	localparam int FAST_HZ = 7_372_800;
	localparam int ACC_W = 24;
	// phase accumulator steps: rate * 2^24 / clock
	localparam logic [ACC_W-1:0] STEP_A = ACC_W'((64'(SLOW_A_HZ) << ACC_W) / CLK_HZ);
	localparam logic [ACC_W-1:0] STEP_B = ACC_W'((64'(SLOW_B_HZ) << ACC_W) / CLK_HZ);
	localparam logic [ACC_W-1:0] STEP_F = ACC_W'((64'(FAST_HZ) << ACC_W) / CLK_HZ);
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] WRAP_VAL = 16'hFFFF;
	localparam int NTMR = 3;
	localparam logic [7:0] OFS_LOAD0 = 8'h00; // per timer block of 0x10
	localparam logic [7:0] OFS_VALUE = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_CLEAR = 8'h0C;
	localparam logic [7:0] OFS_SYSCTL = 8'h40;
	localparam logic [7:0] OFS_STATUS = 8'h44;
	localparam logic [7:0] OFS_MASK = 8'h48;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MODE_BIT = 1; // 1 = periodic reload
	localparam int SYS_SEL1_BIT = 0; // 1 = 2 kHz tick
	localparam int SYS_MODE1_BIT = 1;
	localparam int SYS_SEL2_BIT = 2;
	localparam int SYS_MODE2_BIT = 3;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} tdct_bus_type;
endpackage
`default_nettype wire

// *** logic/tdct_tick.sv ***
// phase accumulator giving one-cycle tick pulses at a fractional rate
// assumes the step is below two to the accumulator width
`default_nettype none
module tdct_tick #(
	parameter logic [tdct_pkg::ACC_W-1:0] STEP = tdct_pkg::STEP_A
) (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	output logic tick // one-cycle enable pulse
);
	logic [tdct_pkg::ACC_W:0] sum;
	logic [tdct_pkg::ACC_W-1:0] acc_q;
	assign sum = {1'b0, acc_q} + {1'b0, STEP};
	// carry out of the accumulator marks a tick
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_q <= '0;
			tick <= 1'b0;
		end else begin
			acc_q <= sum[tdct_pkg::ACC_W-1:0];
			tick <= sum[tdct_pkg::ACC_W];
		end
	end
endmodule
`default_nettype wire

// *** tb/tdct_asserts.sv ***
// port checker for the three down counter timers
// assumes the register map and single clock of tdct_top
`default_nettype none
module tdct_asserts (
	input wire logic clk, // system clock
	input wire logic rst_b, // reset, active low
	input wire tdct_pkg::tdct_bus_type bus, // register port
	input wire logic [31:0] rdata, // read data
	input wire logic [2:0] tmr_irq, // underflow flags
	input wire logic irq // interrupt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] mask_m;
	default clocking @(posedge clk); endclocking
	// mask as written over the port, so the interrupt line can be predicted
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_m <= 3'h0;
		end else if (bus.wr && bus.addr == 8'h48) begin
			mask_m <= bus.wdata[2:0];
		end
	end
	default disable iff (!rst_b);
	// write then read back of one address
	sequence s_wr_rd(logic [7:0] a);
		bus.wr && bus.addr == a ##1 bus.rd && bus.addr == a;
	endsequence
	// relations between strobes, data and flags
	a_load_readback: assert property (s_wr_rd(8'h00) |=>
		rdata[15:0] == $past(bus.wdata[15:0], 2)) else $error("load not read back");
	a_ctrl_readback: assert property (s_wr_rd(8'h08) |=>
		rdata[1:0] == $past(bus.wdata[1:0], 2)) else $error("control not read back");
	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data outside read slot");
	a_value_width: assert property ($past(bus.rd) && $past(bus.addr[3:0]) == 4'h4
		|-> rdata[31:16] == 16'h0) else $error("count wider than 16 bits");
	a_unmapped_zero: assert property (bus.rd && bus.addr == 8'h50 |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	a_irq_cause: assert property (irq == |(tmr_irq & mask_m))
		else $error("interrupt without flag");
	a_mask_off: assert property (bus.wr && bus.addr == 8'h48 && bus.wdata == 32'h0
		|=> !irq) else $error("masked interrupt still high");
	a_flag_sticky: assert property ($fell(tmr_irq[2]) |-> $past(bus.wr) &&
		$past(bus.addr) inside {8'h2C, 8'h44}) else $error("flag fell without clear");
	a_flag_hold: assert property ($fell(tmr_irq[0]) |-> $past(bus.wr) &&
		$past(bus.addr) inside {8'h0C, 8'h44}) else $error("flag fell without clear");
endmodule
bind tdct_top tdct_asserts tdct_asserts_inst (.clk(clk), .rst_b(rst_b), .bus(bus),
	.rdata(rdata), .tmr_irq(tmr_irq), .irq(irq));
`default_nettype wire

// *** tb/tdct_top_tb.sv ***
// self-checking bench for the three down counter timers
// assumes tdct_top with read data one cycle after the strobe
`default_nettype none
module tdct_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	tdct_pkg::tdct_bus_type bus = '0;
	logic [31:0] rdata, r, v;
	logic [2:0] tmr_irq;
	logic irq;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tdct_row_type;
	tdct_row_type rows [6] = '{'{8'h00, 32'h00012345, 32'h00002345},
		'{8'h08, 32'h2, 32'h2}, '{8'h40, 32'h2, 32'h2}, '{8'h48, 32'h7, 32'h7},
		'{8'h50, 32'hFF, 32'h0}, '{8'h10, 32'h0001FFFF, 32'h0000FFFF}};
	// 10 MHz clock
	always #50 clk = ~clk;
	tdct_top tdct_top_inst (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
		.tmr_irq(tmr_irq), .irq(irq));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one strobe, read data taken in the following cycle
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{a, d, w, ~w};
		@(posedge clk);
		bus <= '{a, d, 1'b0, 1'b0};
		#1 r = rdata;
	endtask
	// write followed at once by a read of the same place
	task automatic rdb(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		acc(1'b0, a, d);
	endtask
	// load and start a timer, wait for its flag, then read the count
	task automatic uf(input int i, input logic [7:0] b, input logic [31:0] ld, c);
		int n;
		acc(1'b1, b, ld);
		acc(1'b1, b + 8'h08, c);
		for (n = 0; n < 400 && tmr_irq[i] !== 1'b1; n++) #100;
		if (n == 400) begin
			fails++;
			complete_run();
		end
		acc(1'b0, b + 8'h04, 32'h0);
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		acc(1'b0, 8'h14, 32'h0);
		chk(r, 32'h0);
		chk({28'h0, tmr_irq, irq}, 32'h0);
		$display("reset test done");
		foreach (rows[k]) begin
			rdb(rows[k].a, rows[k].d);
			chk(r, rows[k].e);
		end
		acc(1'b0, 8'h04, 32'h0);
		chk(r, 32'h00002345);
		$display("table test done");
		uf(0, 8'h00, 32'h1, 32'h1);
		chk(r & 32'hFFFFFFFE, 32'h0);
		chk({31'h0, irq}, 32'h1);
		acc(1'b1, 8'h08, 32'h0);
		acc(1'b1, 8'h0C, 32'h0);
		chk({31'h0, tmr_irq[0]}, 32'h0);
		$display("slow reload test done");
		uf(2, 8'h20, 32'h1, 32'h1);
		chk(r & 32'hFFFFFFF0, 32'h0000FFF0);
		acc(1'b1, 8'h28, 32'h0);
		acc(1'b0, 8'h24, 32'h0);
		v = r;
		acc(1'b1, 8'h2C, 32'h0);
		repeat (10) @(posedge clk);
		acc(1'b0, 8'h24, 32'h0);
		chk(r, v);
		chk({28'h0, tmr_irq, irq}, 32'h0);
		$display("fast free test done");
		uf(2, 8'h20, 32'h3, 32'h3);
		chk(r & 32'hFFFFFFFC, 32'h0);
		acc(1'b1, 8'h28, 32'h0);
		acc(1'b1, 8'h48, 32'h0);
		chk({31'h0, irq}, 32'h0);
		acc(1'b1, 8'h48, 32'h4);
		chk({31'h0, irq}, 32'h1);
		acc(1'b1, 8'h44, 32'h4);
		chk({28'h0, tmr_irq, irq}, 32'h0);
		$display("reload and mask test done");
		// second slow timer on the 2 kHz source, free running from one
		acc(1'b1, 8'h40, 32'h4);
		acc(1'b1, 8'h10, 32'h1);
		acc(1'b1, 8'h18, 32'h1);
		for (cyc = 0; cyc < 10100 && tmr_irq[1] !== 1'b1; cyc++) @(posedge clk);
		if (cyc == 10100) begin
			fails++;
			complete_run();
		end
		chk({31'h0, cyc >= 4900}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		acc(1'b0, 8'h14, 32'h0);
		chk(r, 32'h0000FFFF);
		acc(1'b1, 8'h18, 32'h0);
		acc(1'b1, 8'h1C, 32'h0);
		chk({31'h0, tmr_irq[1]}, 32'h0);
		$display("slow source test done");
		complete_run();
	end
endmodule
`default_nettype wire
